// ---- logic/mhus_pkg.sv ----
// Constants, carrier types and reset values of the host serial block.
// Assumes a single 50 MHz clock and a host that keeps to 8n1 framing.
package mhus_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int BAUD_LOW = 9600;
  localparam int BAUD_MID = 57600;
  localparam int BAUD_HIGH = 115200;
  localparam int DIV_LOW = CLK_HZ / BAUD_LOW;
  localparam int DIV_MID = CLK_HZ / BAUD_MID;
  localparam int DIV_HIGH = CLK_HZ / BAUD_HIGH;
  localparam int READY_MS = 1125;
  localparam int READY_CYC = READY_MS * (CLK_HZ / 1000);
  localparam int RESET_HOLD_MS = 1;

  // ----------------------------------------
  // Framing
  // ----------------------------------------
  localparam logic [3:0] FRAME_BITS = 4'hA;
  localparam logic [3:0] STOP_BIT = 4'h9;
  localparam logic [12:0] CNT_ONE = 13'h0001;

  // ----------------------------------------
  // Baud codes, commands and ready notice length
  // ----------------------------------------
  localparam logic [1:0] BAUD_SEL_LOW = 2'h0;
  localparam logic [1:0] BAUD_SEL_MID = 2'h1;
  localparam logic [1:0] BAUD_SEL_HIGH = 2'h2;
  localparam logic [7:0] CMD_BAUD_LOW = 8'hB0;
  localparam logic [7:0] CMD_BAUD_MID = 8'hB1;
  localparam logic [7:0] CMD_BAUD_HIGH = 8'hB2;
  localparam logic [7:0] CMD_SLEEP = 8'h5A;
  localparam logic [2:0] NOTE_LAST = 3'h6;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int ST_SLEEP = 2;
  localparam int ST_BOOT = 3;
  localparam int ST_READY = 4;
  localparam int ST_FERR = 5;

  // ----------------------------------------
  // Pin synchroniser lanes
  // ----------------------------------------
  localparam int SYN_ARX = 0;
  localparam int SYN_BRX = 1;
  localparam int SYN_BOOT = 2;
  localparam int SYN_WAKE = 3;
  localparam logic [3:0] SYNC_RST = 4'hB;

  typedef struct packed {
    logic busy;
    logic [12:0] cnt;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic done;
    logic ferr;
  } mhus_rx_type;

  typedef struct packed {
    logic busy;
    logic [12:0] cnt;
    logic [3:0] bitn;
    logic [9:0] sh;
  } mhus_tx_type;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    mhus_rx_type arx;
    mhus_rx_type brx;
    mhus_tx_type atx;
    mhus_tx_type btx;
    logic [1:0] baud;
    logic sleep;
    logic boot;
    logic [25:0] rcnt;
    logic rdone;
    logic nbusy;
    logic [2:0] nidx;
    logic [1:0] ferr;
    logic [7:0] ardata;
    logic avalid;
    logic [7:0] fdata;
    logic fvalid;
    logic [7:0] rdata;
  } mhus_state_type;

  localparam mhus_tx_type TX_RST = '{sh: 10'h3FF, default: '0};
  localparam mhus_state_type ST_RST_VAL = '{s1: SYNC_RST, s2: SYNC_RST, atx: TX_RST,
                                            btx: TX_RST, default: '0};

endpackage

// ---- logic/mhus_top.sv ----
// Host-facing serial side: application port, bootloader port, start-up notice.
// Assumes the host reset pin drives arst_n_i; the serial inputs, boot select and wake are asynchronous.
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module mhus_top #(
  parameter logic [25:0] READY_CYCLES = 26'(mhus_pkg::READY_CYC),
  parameter logic [12:0] DIV_APP_LOW = 13'(mhus_pkg::DIV_LOW)
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic app_serial_rx_i,
  output logic app_serial_tx_o,
  input wire logic boot_serial_rx_i,
  output logic boot_serial_tx_o,
  input wire logic boot_select_i,
  input wire logic wake_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [7:0] app_tx_data_i,
  input wire logic app_tx_valid_i,
  output logic app_tx_ready_o,
  output logic [7:0] app_rx_data_o,
  output logic app_rx_valid_o,
  input wire logic [7:0] boot_tx_data_i,
  input wire logic boot_tx_valid_i,
  output logic boot_tx_ready_o,
  output logic [7:0] fw_data_o,
  output logic fw_valid_o,
  output logic sleep_o,
  output logic boot_mode_o,
  output logic ready_sent_o
);

  mhus_pkg::mhus_state_type st_q;
  mhus_pkg::mhus_state_type st_d;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [12:0] div_of(input logic [1:0] sel);
    logic [12:0] d;
    d = DIV_APP_LOW;
    if (sel == mhus_pkg::BAUD_SEL_MID) begin
      d = 13'(mhus_pkg::DIV_MID);
    end else if (sel == mhus_pkg::BAUD_SEL_HIGH) begin
      d = 13'(mhus_pkg::DIV_HIGH);
    end
    return d;
  endfunction

  function automatic logic [7:0] note_byte(input logic [2:0] idx);
    logic [7:0] b;
    b = 8'h0A;
    case (idx)
      3'h0: b = 8'h52;
      3'h1: b = 8'h45;
      3'h2: b = 8'h41;
      3'h3: b = 8'h44;
      3'h4: b = 8'h59;
      3'h5: b = 8'h0D;
      default: b = 8'h0A;
    endcase
    return b;
  endfunction

  function automatic mhus_pkg::mhus_rx_type rx_step(input mhus_pkg::mhus_rx_type rx,
                                                    input logic line,
                                                    input logic [12:0] div);
    mhus_pkg::mhus_rx_type r;
    r = rx;
    r.done = 1'b0;
    r.ferr = 1'b0;
    if (!r.busy) begin
      if (!line) begin
        r.busy = 1'b1;
        r.cnt = div >> 1;
        r.bitn = '0;
      end
    end else if (r.cnt != '0) begin
      r.cnt = r.cnt - mhus_pkg::CNT_ONE;
    end else begin
      r.cnt = div - mhus_pkg::CNT_ONE;
      if (r.bitn == '0) begin
        // False start: glitch shorter than half a bit
        r.busy = !line;
      end else if (r.bitn == mhus_pkg::STOP_BIT) begin
        r.busy = 1'b0;
        r.done = line;
        r.ferr = !line;
      end else begin
        r.sh = {line, r.sh[7:1]};
      end
      r.bitn = r.bitn + 4'h1;
    end
    return r;
  endfunction

  function automatic mhus_pkg::mhus_tx_type tx_step(input mhus_pkg::mhus_tx_type tx,
                                                    input logic start,
                                                    input logic [7:0] data,
                                                    input logic [12:0] div);
    mhus_pkg::mhus_tx_type t;
    t = tx;
    if (!t.busy) begin
      if (start) begin
        t.busy = 1'b1;
        t.cnt = div - mhus_pkg::CNT_ONE;
        t.bitn = '0;
        t.sh = {1'b1, data, 1'b0};
      end
    end else if (t.cnt != '0) begin
      t.cnt = t.cnt - mhus_pkg::CNT_ONE;
    end else begin
      t.cnt = div - mhus_pkg::CNT_ONE;
      t.sh = {1'b1, t.sh[9:1]};
      if (t.bitn == mhus_pkg::FRAME_BITS - 4'h1) begin
        t.busy = 1'b0;
      end
      t.bitn = t.bitn + 4'h1;
    end
    return t;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic [12:0] app_div;
  logic [12:0] boot_div;
  logic app_start;
  logic [7:0] app_byte;
  logic note_start;

  assign app_div = div_of(st_q.baud);
  assign boot_div = 13'(mhus_pkg::DIV_HIGH);
  assign note_start = st_q.nbusy && !st_q.atx.busy;
  assign app_tx_ready_o = st_q.rdone && !st_q.nbusy && !st_q.atx.busy;
  assign boot_tx_ready_o = st_q.boot && !st_q.btx.busy;
  assign app_start = note_start || (app_tx_valid_i && app_tx_ready_o);
  assign app_byte = note_start ? note_byte(st_q.nidx) : app_tx_data_i;

  always_comb begin
    st_d = st_q;
    st_d.s1 = {wake_n_i, boot_select_i, boot_serial_rx_i, app_serial_rx_i};
    st_d.s2 = st_q.s1;
    st_d.arx = rx_step(st_q.arx, st_q.s2[mhus_pkg::SYN_ARX], app_div);
    st_d.brx = rx_step(st_q.brx, st_q.s2[mhus_pkg::SYN_BRX], boot_div);
    st_d.atx = tx_step(st_q.atx, app_start, app_byte, app_div);
    st_d.btx = tx_step(st_q.btx, boot_tx_valid_i && boot_tx_ready_o, boot_tx_data_i,
                       boot_div);
    st_d.boot = st_q.s2[mhus_pkg::SYN_BOOT];
    st_d.avalid = 1'b0;
    st_d.fvalid = 1'b0;
    st_d.rdata = '0;
    // Commands are consumed here and never forwarded
    if (st_q.arx.done) begin
      if (st_q.arx.sh == mhus_pkg::CMD_BAUD_LOW) begin
        st_d.baud = mhus_pkg::BAUD_SEL_LOW;
      end else if (st_q.arx.sh == mhus_pkg::CMD_BAUD_MID) begin
        st_d.baud = mhus_pkg::BAUD_SEL_MID;
      end else if (st_q.arx.sh == mhus_pkg::CMD_BAUD_HIGH) begin
        st_d.baud = mhus_pkg::BAUD_SEL_HIGH;
      end else if (st_q.arx.sh == mhus_pkg::CMD_SLEEP) begin
        st_d.sleep = 1'b1;
      end else begin
        st_d.ardata = st_q.arx.sh;
        st_d.avalid = 1'b1;
      end
    end
    // wake wins over a sleep command
    if (!st_q.s2[mhus_pkg::SYN_WAKE]) begin
      st_d.sleep = 1'b0;
    end
    if (st_q.brx.done && st_q.boot) begin
      st_d.fdata = st_q.brx.sh;
      st_d.fvalid = 1'b1;
    end
    if (!st_q.rdone && !st_q.nbusy) begin
      if (st_q.rcnt == READY_CYCLES - 26'h000_0001) begin
        st_d.nbusy = 1'b1;
      end else begin
        st_d.rcnt = st_q.rcnt + 26'h000_0001;
      end
    end
    if (note_start) begin
      st_d.nidx = st_q.nidx + 3'h1;
      if (st_q.nidx == mhus_pkg::NOTE_LAST) begin
        st_d.nbusy = 1'b0;
        st_d.rdone = 1'b1;
      end
    end
    // Register port; a rate change takes effect mid-frame, so change when idle
    if (reg_wr_i && reg_addr_i == mhus_pkg::REG_CTRL &&
        reg_wdata_i[1:0] != 2'h3) begin
      st_d.baud = reg_wdata_i[1:0];
    end
    if (reg_wr_i && reg_addr_i == mhus_pkg::REG_STATUS) begin
      st_d.ferr = st_q.ferr & ~reg_wdata_i[mhus_pkg::ST_FERR +: 2];
    end
    st_d.ferr = st_d.ferr | {st_q.brx.ferr, st_q.arx.ferr};
    if (reg_rd_i && reg_addr_i == mhus_pkg::REG_CTRL) begin
      st_d.rdata = {6'h00, st_q.baud};
    end else if (reg_rd_i && reg_addr_i == mhus_pkg::REG_STATUS) begin
      st_d.rdata = {1'b0, st_q.ferr, st_q.rdone, st_q.boot, st_q.sleep, st_q.baud};
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= mhus_pkg::ST_RST_VAL;
    end else begin
      st_q <= st_d;
    end
  end

  assign app_serial_tx_o = st_q.atx.sh[0];
  assign boot_serial_tx_o = st_q.btx.sh[0];
  assign reg_rdata_o = st_q.rdata;
  assign app_rx_data_o = st_q.ardata;
  assign app_rx_valid_o = st_q.avalid;
  assign fw_data_o = st_q.fdata;
  assign fw_valid_o = st_q.fvalid;
  assign sleep_o = st_q.sleep;
  assign boot_mode_o = st_q.boot;
  assign ready_sent_o = st_q.rdone;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  baud_default_a: assert property ($rose(arst_n_i) |->
    st_q.baud == mhus_pkg::BAUD_SEL_LOW) else $error("baud not default after reset");
  baud_cmd_a: assert property (st_q.arx.done && st_q.arx.sh == mhus_pkg::CMD_BAUD_HIGH &&
    !reg_wr_i |=> st_q.baud == mhus_pkg::BAUD_SEL_HIGH) else $error("baud command lost");
  frame_start_a: assert property (st_q.atx.busy && st_q.atx.bitn == '0 |->
    !app_serial_tx_o) else $error("start bit not low");
  frame_stop_a: assert property (st_q.atx.busy && st_q.atx.bitn == mhus_pkg::STOP_BIT |->
    app_serial_tx_o) else $error("stop bit not high");
  boot_rate_a: assert property (st_q.btx.cnt <= 13'(mhus_pkg::DIV_HIGH) - 13'h0001 &&
    st_q.brx.cnt <= 13'(mhus_pkg::DIV_HIGH)) else $error("boot port off rate");
  fw_source_a: assert property (fw_valid_o |-> $past(st_q.brx.done) &&
    $past(st_q.boot)) else $error("firmware byte from wrong port");
  ready_note_a: assert property (!st_q.rdone && !st_q.nbusy &&
    st_q.rcnt == READY_CYCLES - 26'h000_0001 |=> st_q.nbusy ##1 !app_serial_tx_o)
    else $error("ready notice not started");
  boot_follow_a: assert property (st_q.s2[mhus_pkg::SYN_BOOT] |=> boot_mode_o)
    else $error("boot mode not entered");
  wake_exit_a: assert property (!st_q.s2[mhus_pkg::SYN_WAKE] |=> !sleep_o)
    else $error("wake did not leave sleep");
  sleep_cause_a: assert property ($rose(sleep_o) |-> $past(st_q.arx.done) &&
    $past(st_q.arx.sh) == mhus_pkg::CMD_SLEEP) else $error("sleep without command");
  ferr_drop_a: assert property (st_q.arx.ferr |=> !app_rx_valid_o &&
    st_q.ferr[0]) else $error("framing error not flagged");

  tx_idle_a: assert property (!st_q.atx.busy |-> app_serial_tx_o)
    else $error("app line not idle high");
  bit_hold_a: assert property (st_q.atx.busy && st_q.atx.cnt != '0 |=>
    $stable(app_serial_tx_o)) else $error("app bit cut short");
  boot_idle_a: assert property (!st_q.btx.busy |-> boot_serial_tx_o)
    else $error("boot line not idle high");
  boot_hold_a: assert property (st_q.btx.busy && st_q.btx.cnt != '0 |=>
    $stable(boot_serial_tx_o)) else $error("boot bit cut short");
  baud_hold_a: assert property (!st_q.arx.done && !reg_wr_i |=>
    $stable(st_q.baud)) else $error("baud changed without request");
  boot_drop_a: assert property (st_q.brx.done && !st_q.boot |=> !fw_valid_o)
    else $error("boot byte passed outside boot mode");
  notice_done_a: assert property (note_start && st_q.nidx == mhus_pkg::NOTE_LAST |=>
    ready_sent_o) else $error("ready flag not set after notice");
  boot_leave_a: assert property (!st_q.s2[mhus_pkg::SYN_BOOT] |=> !boot_mode_o)
    else $error("boot mode not left");
  sleep_hold_a: assert property (sleep_o && st_q.s2[mhus_pkg::SYN_WAKE] |=> sleep_o)
    else $error("sleep left without wake");
  cmd_drop_a: assert property (st_q.arx.done && st_q.arx.sh == mhus_pkg::CMD_SLEEP |=>
    !app_rx_valid_o) else $error("sleep command forwarded");
  rx_valid_a: assert property (app_rx_valid_o |-> $past(st_q.arx.done))
    else $error("byte without valid stop bit");
  boot_ferr_a: assert property (st_q.brx.ferr |=> !fw_valid_o && st_q.ferr[1])
    else $error("boot framing error not flagged");

  ready_sent_c: cover property ($rose(ready_sent_o));
  fw_byte_c: cover property (fw_valid_o);
  sleep_wake_c: cover property ($rose(sleep_o) ##[1:1000] $fell(sleep_o));
  app_byte_c: cover property (app_rx_valid_o);
  baud_high_c: cover property (st_q.baud == mhus_pkg::BAUD_SEL_HIGH);

endmodule

// ---- sim/mhus_host_model.sv ----
// Host side of both serial links: byte sender and line decoders.
// Assumes the bench supplies the application divisor in clock cycles.
`timescale 1ns/100ps
module mhus_host_model (
  input wire logic clk_i,
  input wire logic app_tx_i,
  input wire logic boot_tx_i,
  input wire logic [12:0] app_div_i,
  output logic app_rx_o,
  output logic boot_rx_o
);
  logic [7:0] app_q[$];
  logic [7:0] boot_q[$];
  logic [7:0] ab;
  logic [7:0] bb;

  // Idle lines rest high between frames
  initial begin
    app_rx_o = 1'b1;
    boot_rx_o = 1'b1;
  end

  // ----------------------------------------
  // Sender
  // ----------------------------------------
  // start, eight data LSB first, stop
  task automatic send(input logic k, input logic [7:0] d, input logic stop,
                      input logic [12:0] div);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      if (k) boot_rx_o <= f[i];
      else app_rx_o <= f[i];
      repeat (div - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    app_rx_o <= 1'b1;
    boot_rx_o <= 1'b1;
  endtask

  // ----------------------------------------
  // Decoders
  // ----------------------------------------
  // sample at centres, low stop drops the byte
  task automatic grab(input logic k, input logic [12:0] div, output logic [7:0] d,
                      output logic ok);
    repeat (div / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge clk_i);
      d[i] = k ? boot_tx_i : app_tx_i;
    end
    repeat (div) @(posedge clk_i);
    ok = k ? boot_tx_i : app_tx_i;
  endtask

  always begin : app_dec
    logic ok;
    @(negedge app_tx_i);
    grab(1'b0, app_div_i, ab, ok);
    if (ok) app_q.push_back(ab);
  end

  always begin : boot_dec
    logic ok;
    @(negedge boot_tx_i);
    grab(1'b1, 13'(mhus_pkg::DIV_HIGH), bb, ok);
    if (ok) boot_q.push_back(bb);
  end
endmodule

// ---- sim/mhus_top_tb.sv ----
// Self-checking bench of the host serial block.
// Assumes a shortened ready delay and low-rate divisor for run time.
`timescale 1ns/100ps
module mhus_top_tb;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic app_rx, boot_rx, app_tx, boot_tx;
  logic boot_select_i = 1'b0;
  logic wake_n_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o, app_tx_data_i, app_rx_data_o, boot_tx_data_i, fw_data_o;
  logic app_tx_valid_i = 1'b0;
  logic boot_tx_valid_i = 1'b0;
  logic app_tx_ready_o, app_rx_valid_o, boot_tx_ready_o, fw_valid_o;
  logic sleep_o, boot_mode_o, ready_sent_o;
  logic [12:0] div = 13'd200;
  logic [7:0] d, rx_q[$], fw_q[$];
  int err_count = 0;
  int check_count = 0;
  logic [12:0] divs[3] = '{13'd200, 13'(mhus_pkg::DIV_MID), 13'(mhus_pkg::DIV_HIGH)};
  logic [7:0] note[7] = '{8'h52, 8'h45, 8'h41, 8'h44, 8'h59, 8'h0D, 8'h0A};

  always #10 clk_i = ~clk_i;
  initial begin
    app_tx_data_i = 8'h00;
    boot_tx_data_i = 8'h00;
  end

  mhus_top #(.READY_CYCLES(26'd200), .DIV_APP_LOW(13'd200)) mhus_top_i (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .app_serial_rx_i(app_rx), .app_serial_tx_o(app_tx),
    .boot_serial_rx_i(boot_rx), .boot_serial_tx_o(boot_tx), .boot_select_i(boot_select_i),
    .wake_n_i(wake_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .app_tx_data_i(app_tx_data_i), .app_tx_valid_i(app_tx_valid_i),
    .app_tx_ready_o(app_tx_ready_o), .app_rx_data_o(app_rx_data_o),
    .app_rx_valid_o(app_rx_valid_o), .boot_tx_data_i(boot_tx_data_i),
    .boot_tx_valid_i(boot_tx_valid_i), .boot_tx_ready_o(boot_tx_ready_o),
    .fw_data_o(fw_data_o), .fw_valid_o(fw_valid_o), .sleep_o(sleep_o),
    .boot_mode_o(boot_mode_o), .ready_sent_o(ready_sent_o));

  mhus_host_model mhus_host_model_i (.clk_i(clk_i), .app_tx_i(app_tx), .boot_tx_i(boot_tx),
    .app_div_i(div), .app_rx_o(app_rx), .boot_rx_o(boot_rx));

  always @(posedge clk_i) begin
    if (app_rx_valid_o === 1'b1) rx_q.push_back(app_rx_data_o);
    if (fw_valid_o === 1'b1) fw_q.push_back(fw_data_o);
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
    @(posedge clk_i);
  endtask

  function automatic int qsz(input int k);
    return k == 0 ? mhus_host_model_i.app_q.size() : k == 1 ? mhus_host_model_i.boot_q.size()
      : k == 2 ? rx_q.size() : fw_q.size();
  endfunction

  // Bounded wait; a missing byte counts as a mismatch
  task automatic take(input int k, output logic [7:0] v);
    int n;
    n = 0;
    while (qsz(k) == 0 && n < 40000) begin
      @(posedge clk_i);
      n++;
    end
    v = 8'hxx;
    if (k == 0 && n < 40000) v = mhus_host_model_i.app_q.pop_front();
    if (k == 1 && n < 40000) v = mhus_host_model_i.boot_q.pop_front();
    if (k == 2 && n < 40000) v = rx_q.pop_front();
    if (k == 3 && n < 40000) v = fw_q.pop_front();
  endtask

  task automatic user_tx(input logic k, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    if (k) begin
      boot_tx_valid_i <= 1'b1;
      boot_tx_data_i <= v;
    end else begin
      app_tx_valid_i <= 1'b1;
      app_tx_data_i <= v;
    end
    do begin
      @(negedge clk_i);
      n++;
    end while ((k ? boot_tx_ready_o : app_tx_ready_o) !== 1'b1 && n < 40000);
    @(posedge clk_i);
    app_tx_valid_i <= 1'b0;
    boot_tx_valid_i <= 1'b0;
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    // reset held well past one edge
    repeat (16) @(posedge clk_i);
    check(8'(app_tx), 8'h01);
    arst_n_i <= 1'b1;
    reg_rd(mhus_pkg::REG_CTRL, d);
    check(d, 8'h00);
    check(8'(app_tx_ready_o), 8'h00);
    reg_rd(8'h10, d);
    check(d, 8'h00);
    for (int i = 0; i < 7; i++) begin
      take(0, d);
      check(d, note[i]);
    end
    repeat (300) @(posedge clk_i);
    check(8'(ready_sent_o), 8'h01);
    // Every baud code, then traffic both ways at the new rate
    for (int i = 1; i < 4; i++) begin
      mhus_host_model_i.send(1'b0, 8'hB0 + 8'(i % 3), 1'b1, div);
      repeat (10) @(posedge clk_i);
      div = divs[i % 3];
      reg_rd(mhus_pkg::REG_CTRL, d);
      check(d, 8'(i % 3));
      mhus_host_model_i.send(1'b0, 8'h3C + 8'(i), 1'b1, div);
      take(2, d);
      check(d, 8'h3C + 8'(i));
      user_tx(1'b0, 8'hA5 ^ 8'(i));
      take(0, d);
      check(d, 8'hA5 ^ 8'(i));
    end
    reg_wr(mhus_pkg::REG_CTRL, 8'h03);
    reg_rd(mhus_pkg::REG_CTRL, d);
    check(d, 8'h00);
    // Low stop bit: byte dropped, error flagged then cleared
    mhus_host_model_i.send(1'b0, 8'h77, 1'b0, div);
    repeat (10) @(posedge clk_i);
    reg_rd(mhus_pkg::REG_STATUS, d);
    check(d & 8'h20, 8'h20);
    check(8'(rx_q.size()), 8'h00);
    reg_wr(mhus_pkg::REG_STATUS, 8'h20);
    reg_rd(mhus_pkg::REG_STATUS, d);
    check(d & 8'h20, 8'h00);
    // Boot link: ignored until boot mode, then both ways
    mhus_host_model_i.send(1'b1, 8'h11, 1'b1, 13'(mhus_pkg::DIV_HIGH));
    repeat (10) @(posedge clk_i);
    check(8'(fw_q.size()), 8'h00);
    boot_select_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    check(8'(boot_mode_o), 8'h01);
    mhus_host_model_i.send(1'b1, 8'h22, 1'b1, 13'(mhus_pkg::DIV_HIGH));
    take(3, d);
    check(d, 8'h22);
    user_tx(1'b1, 8'h5E);
    take(1, d);
    check(d, 8'h5E);
    mhus_host_model_i.send(1'b0, 8'h33, 1'b1, div);
    take(2, d);
    check(d, 8'h33);
    check(8'(fw_q.size() + 8'(sleep_o)), 8'h00);
    boot_select_i <= 1'b0;
    // Sleep by command, wake by low level
    mhus_host_model_i.send(1'b0, mhus_pkg::CMD_SLEEP, 1'b1, div);
    repeat (10) @(posedge clk_i);
    check(8'(sleep_o), 8'h01);
    reg_rd(mhus_pkg::REG_STATUS, d);
    check(d & 8'h04, 8'h04);
    wake_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check(8'(sleep_o), 8'h00);
    wake_n_i <= 1'b1;
    // Reset in mid-run restores defaults
    reg_wr(mhus_pkg::REG_CTRL, 8'h02);
    reg_rd(mhus_pkg::REG_CTRL, d);
    check(d, 8'h02);
    arst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check(8'(ready_sent_o), 8'h00);
    arst_n_i <= 1'b1;
    reg_rd(mhus_pkg::REG_CTRL, d);
    check(d, 8'h00);
    give_verdict();
  end

  initial begin
    repeat (95000) @(posedge clk_i);
    err_count++;
    give_verdict();
  end
endmodule
